// *** rtl/adsc_clkdiv.sv ***
// converter clock divider: one-cycle enable pulse at the system clock divided by 1..64
// assumes sel and run come from logic on the same clock
`timescale 1ns/100ps

module adsc_clkdiv
	import adsc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// sequencer side
	adsc_div_if.div dv
);

	adsc_div_t cnt_ff;
	adsc_div_t nxt_cnt;
	logic tick_ff;
	logic nxt_tick;

	// held clear while idle so every conversion sees whole converter periods from its start
	always_comb begin
		nxt_cnt = '0;
		nxt_tick = 1'b0;
		if (dv.run) begin
			if ((cnt_ff & adsc_div_mask(dv.sel)) == adsc_div_mask(dv.sel)) begin
				nxt_cnt = '0;
				nxt_tick = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 6'h01;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign dv.tick = tick_ff;

endmodule // adsc_clkdiv

// *** rtl/adsc_defines.svh ***
// constants for the converter sequencing control: conversion timing, result layout, reset values
// assumes it is included by the package and by the design modules, never compiled alone
`ifndef ADSC_DEFINES_SVH
`define ADSC_DEFINES_SVH

`define ADSC_RES_W 12
`define ADSC_CONV_PERIODS 16
`define ADSC_SAMPLE_PERIODS 2
`define ADSC_FULL_SCALE 12'hfff
`define ADSC_RESULT_RST 12'h000
`define ADSC_BUSY_RST 1'b0
`define ADSC_DIV_W 6
`define ADSC_NUM_PINS 8

`endif

// *** rtl/adsc_div_if.sv ***
// link between the sequencer and its converter clock divider
// assumes both ends run on the same system clock
`timescale 1ns/100ps

interface adsc_div_if;
	logic [2:0] sel;
	logic run;
	logic tick;

	modport ctrl (output sel, output run, input tick);
	modport div (input sel, input run, output tick);
endinterface // adsc_div_if

// *** rtl/adsc_pkg.sv ***
// types shared by the converter sequencing control and its clock divider
// assumes adsc_defines.svh is on the include path
`include "adsc_defines.svh"

package adsc_pkg;

	typedef enum logic [1:0] {
		ST_OFF,
		ST_IDLE,
		ST_HOLD,
		ST_CONV
	} adsc_state_e;

	typedef logic [`ADSC_DIV_W-1:0] adsc_div_t;

	// terminal-count mask of the converter clock divider, one bit per power of two
	function automatic adsc_div_t adsc_div_mask(input logic [2:0] sel);
		adsc_div_t m;
		m = '0;
		case (sel)
			3'h0: m = 6'h00;
			3'h1: m = 6'h01;
			3'h2: m = 6'h03;
			3'h3: m = 6'h07;
			3'h4: m = 6'h0f;
			3'h5: m = 6'h1f;
			default: m = 6'h3f; // 111 has no defined rate; it runs as /64 rather than stalling
		endcase
		return m;
	endfunction

endpackage

// *** rtl/adsc_top.sv ***
// successive-approximation sequencing control: power, reference and pin steering, start/busy,
// conversion timing, result and interrupt request
// assumes control bits come from a register file on ref_clk_i; the comparator output is analog
// and asynchronous, so it is synchronised here
`timescale 1ns/100ps
`include "adsc_defines.svh"

module adsc_top
	import adsc_pkg::*;
#(
	parameter int RES_W = `ADSC_RES_W,
	parameter int CONV_PERIODS = `ADSC_CONV_PERIODS,
	parameter int SAMPLE_PERIODS = `ADSC_SAMPLE_PERIODS,
	parameter int NUM_PINS = `ADSC_NUM_PINS
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// control bits
	input wire logic converter_power_down_i,
	input wire logic reference_source_sel_i,
	input wire logic [2:0] conv_clock_divider_sel_i,
	input wire logic extended_channel_sel_i,
	input wire logic [2:0] channel_select_field_i,
	input wire logic start_i,
	input wire logic global_irq_enable_i,
	input wire logic converter_irq_enable_i,
	input wire logic irq_flag_clr_i,
	// pin configuration from the port logic
	input wire logic [NUM_PINS-1:0] analog_pin_enables_i,
	input wire logic [NUM_PINS-1:0] port_direction_in_i,
	input wire logic [NUM_PINS-1:0] pullup_en_i,
	// analog core
	input wire logic comparator_i,
	output logic converter_powered_o,
	output logic sample_o,
	output logic [RES_W-1:0] dac_code_o,
	output logic [3:0] channel_o,
	output logic vref_pin_ref_o,
	output logic vref_pin_other_en_o,
	// pin steering
	output logic [NUM_PINS-1:0] pin_analog_o,
	output logic [NUM_PINS-1:0] pin_digital_en_o,
	output logic [NUM_PINS-1:0] pin_dir_in_o,
	output logic [NUM_PINS-1:0] pin_pullup_o,
	// status
	output logic conversion_busy_flag_o,
	output logic [RES_W-1:0] result_o,
	output logic irq_flag_o,
	output logic irq_o
);

	localparam int CW = $clog2(CONV_PERIODS);
	localparam logic [CW-1:0] LAST_P = CW'(CONV_PERIODS - 1);
	localparam logic [CW-1:0] SAMP_END = CW'(SAMPLE_PERIODS - 1);
	localparam logic [CW-1:0] BIT_FIRST = CW'(SAMPLE_PERIODS);
	localparam logic [CW-1:0] BIT_LAST = CW'(SAMPLE_PERIODS + RES_W - 1);

	// refused at elaboration: the period counter needs at least two states and room for every bit
	if (CONV_PERIODS < 2 || SAMPLE_PERIODS < 1 || SAMPLE_PERIODS + RES_W > CONV_PERIODS || RES_W > 16
		|| NUM_PINS < 1) begin : g_param_check
		$error("adsc_top: parameters leave no room for sampling and all result bits");
	end

	adsc_div_if div_if ();

	adsc_clkdiv u_clkdiv (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.dv(div_if.div)
	);

	// comparator synchroniser
	logic comp_meta_ff;
	logic comp_sync_ff;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			comp_meta_ff <= 1'b0;
			comp_sync_ff <= 1'b0;
		end else begin
			comp_meta_ff <= comparator_i;
			comp_sync_ff <= comp_meta_ff;
		end
	end

	// sequencer state
	adsc_state_e state_ff, nxt_state;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic [RES_W-1:0] dac_ff, nxt_dac;
	logic [RES_W-1:0] result_ff, nxt_result;
	logic busy_ff, nxt_busy;
	logic irq_flag_ff, nxt_irq_flag;
	logic irq_ff, nxt_irq;
	logic sample_ff, nxt_sample;
	logic powered_ff, nxt_powered;
	logic done;

	assign div_if.sel = conv_clock_divider_sel_i;
	assign div_if.run = (state_ff == ST_CONV);

	// the comparator is seen through two flops, so it must settle within a converter period
	// minus two system clocks; divider codes 000 and 001 therefore give wrong bits here, a
	// limitation shared with the analog core, whose minimum period they violate anyway
	always_comb begin
		int k;
		k = 0;
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_dac = dac_ff;
		nxt_result = result_ff;
		nxt_busy = busy_ff;
		done = 1'b0;
		if (converter_power_down_i) begin
			nxt_state = ST_OFF;
		end else begin
			case (state_ff)
				ST_OFF: begin
					nxt_state = ST_IDLE;
				end
				ST_IDLE: begin
					if (start_i) begin
						nxt_state = ST_HOLD;
						nxt_busy = 1'b1;
					end
				end
				ST_HOLD: begin
					nxt_busy = 1'b1;
					nxt_cnt = '0;
					nxt_dac = '0;
					if (!start_i)
						nxt_state = ST_CONV;
				end
				ST_CONV: begin
					if (start_i) begin
						nxt_state = ST_HOLD;
					end else if (div_if.tick) begin
						nxt_cnt = cnt_ff + CW'(1);
						if (cnt_ff == SAMP_END)
							nxt_dac[RES_W-1] = 1'b1;
						if (cnt_ff >= BIT_FIRST && cnt_ff <= BIT_LAST) begin
							k = int'(BIT_LAST) - int'(cnt_ff);
							nxt_dac[k] = comp_sync_ff;
							if (k > 0)
								nxt_dac[k-1] = 1'b1;
						end
						if (cnt_ff == LAST_P) begin
							nxt_result = dac_ff;
							nxt_busy = 1'b0;
							done = 1'b1;
							nxt_state = ST_IDLE;
						end
					end
				end
				default: nxt_state = ST_OFF;
			endcase
		end
		nxt_powered = !converter_power_down_i;
		nxt_sample = (nxt_state == ST_CONV) && (nxt_cnt <= SAMP_END);
		// a completion in the cycle of a clear keeps the flag set
		nxt_irq_flag = (irq_flag_ff && !irq_flag_clr_i) || done;
		nxt_irq = nxt_irq_flag && global_irq_enable_i && converter_irq_enable_i;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= ST_OFF;
			cnt_ff <= '0;
			dac_ff <= '0;
			result_ff <= `ADSC_RESULT_RST;
			busy_ff <= `ADSC_BUSY_RST;
			irq_flag_ff <= 1'b0;
			irq_ff <= 1'b0;
			sample_ff <= 1'b0;
			powered_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			dac_ff <= nxt_dac;
			result_ff <= nxt_result;
			busy_ff <= nxt_busy;
			irq_flag_ff <= nxt_irq_flag;
			irq_ff <= nxt_irq;
			sample_ff <= nxt_sample;
			powered_ff <= nxt_powered;
		end
	end

	// pin and reference steering, registered so every output leaves a flop
	logic [NUM_PINS-1:0] analog_ff, nxt_analog;
	logic [NUM_PINS-1:0] digital_ff, nxt_digital;
	logic [NUM_PINS-1:0] dir_ff, nxt_dir;
	logic [NUM_PINS-1:0] pullup_ff, nxt_pullup;
	logic vref_ref_ff, nxt_vref_ref;
	logic vref_other_ff, nxt_vref_other;
	logic [3:0] chan_ff, nxt_chan;

	always_comb begin
		nxt_analog = analog_pin_enables_i;
		nxt_digital = ~analog_pin_enables_i;
		nxt_dir = port_direction_in_i | analog_pin_enables_i;
		nxt_pullup = pullup_en_i & ~analog_pin_enables_i;
		nxt_vref_ref = reference_source_sel_i;
		nxt_vref_other = !reference_source_sel_i;
		nxt_chan = {extended_channel_sel_i, channel_select_field_i};
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			analog_ff <= '0;
			digital_ff <= '1;
			dir_ff <= '1;
			pullup_ff <= '0;
			vref_ref_ff <= 1'b0;
			vref_other_ff <= 1'b1;
			chan_ff <= 4'h0;
		end else begin
			analog_ff <= nxt_analog;
			digital_ff <= nxt_digital;
			dir_ff <= nxt_dir;
			pullup_ff <= nxt_pullup;
			vref_ref_ff <= nxt_vref_ref;
			vref_other_ff <= nxt_vref_other;
			chan_ff <= nxt_chan;
		end
	end

	assign converter_powered_o = powered_ff;
	assign sample_o = sample_ff;
	assign dac_code_o = dac_ff;
	assign channel_o = chan_ff;
	assign vref_pin_ref_o = vref_ref_ff;
	assign vref_pin_other_en_o = vref_other_ff;
	assign pin_analog_o = analog_ff;
	assign pin_digital_en_o = digital_ff;
	assign pin_dir_in_o = dir_ff;
	assign pin_pullup_o = pullup_ff;
	assign conversion_busy_flag_o = busy_ff;
	assign result_o = result_ff;
	assign irq_flag_o = irq_flag_ff;
	assign irq_o = irq_ff;

endmodule // adsc_top

// *** verif/adsc_top_sva.sv ***
// checker for adsc_top: pin steering, power, start/busy timing, result and interrupt request
// assumes it is bound into adsc_top and sees only that module's ports
`timescale 1ns/100ps

module adsc_top_sva #(
	parameter int RES_W = 12,
	parameter int CONV_PERIODS = 16,
	parameter int NUM_PINS = 8
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic converter_power_down_i,
	input wire logic reference_source_sel_i,
	input wire logic [2:0] conv_clock_divider_sel_i,
	input wire logic start_i,
	input wire logic global_irq_enable_i,
	input wire logic converter_irq_enable_i,
	input wire logic [NUM_PINS-1:0] analog_pin_enables_i,
	input wire logic [NUM_PINS-1:0] port_direction_in_i,
	input wire logic [NUM_PINS-1:0] pullup_en_i,
	input wire logic converter_powered_o,
	input wire logic vref_pin_ref_o,
	input wire logic vref_pin_other_en_o,
	input wire logic [NUM_PINS-1:0] pin_analog_o,
	input wire logic [NUM_PINS-1:0] pin_digital_en_o,
	input wire logic [NUM_PINS-1:0] pin_dir_in_o,
	input wire logic [NUM_PINS-1:0] pin_pullup_o,
	input wire logic conversion_busy_flag_o,
	input wire logic [RES_W-1:0] result_o,
	input wire logic irq_flag_o,
	input wire logic irq_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);

	// edges since the falling start step; saturates so a stalled run cannot wrap into a match
	logic [11:0] cnt_ff;
	logic [11:0] nxt_cnt;
	logic start_q_ff;
	always_comb begin
		nxt_cnt = (cnt_ff == 12'hfff) ? cnt_ff : cnt_ff + 12'h001;
		if (start_q_ff && !start_i && conversion_busy_flag_o && !converter_power_down_i) begin
			nxt_cnt = 12'h000;
		end
	end
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_ff <= 12'h000;
			start_q_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			start_q_ff <= start_i;
		end
	end

	sequence s_pulse;
		converter_powered_o && !converter_power_down_i && start_i ##1 !start_i;
	endsequence
	sequence s_held;
		converter_powered_o && !converter_power_down_i && start_i ##1 start_i && !converter_power_down_i;
	endsequence

	AST_POWER: assert property ($past(resetn_i) |-> converter_powered_o == !$past(converter_power_down_i))
		else $error("converter power does not follow power-down");
	AST_VREF: assert property ($past(resetn_i) |-> vref_pin_ref_o == $past(reference_source_sel_i)
		&& vref_pin_other_en_o != vref_pin_ref_o) else $error("reference pin roles wrong");
	AST_ANALOG: assert property ($past(resetn_i) |-> pin_analog_o == $past(analog_pin_enables_i)
		&& pin_digital_en_o == ~$past(analog_pin_enables_i)) else $error("analog pin steering wrong");
	AST_PULLUP: assert property ($past(resetn_i) |-> pin_pullup_o == $past(pullup_en_i & ~analog_pin_enables_i))
		else $error("pull-up kept on analog pin");
	AST_DIR: assert property ($past(resetn_i) |-> pin_dir_in_o == $past(port_direction_in_i | analog_pin_enables_i))
		else $error("analog pin direction not overridden");
	AST_START: assert property (s_pulse |-> conversion_busy_flag_o [*8])
		else $error("busy not held after start pulse");
	AST_HELD: assert property (s_held |=> conversion_busy_flag_o)
		else $error("held start does not keep busy");
	AST_TIME: assert property ($fell(conversion_busy_flag_o) |->
		cnt_ff == (12'(CONV_PERIODS) << conv_clock_divider_sel_i) + 12'h001) else $error("conversion length wrong");
	AST_DONE_IRQ: assert property ($fell(conversion_busy_flag_o) |-> irq_flag_o)
		else $error("no interrupt request at end of conversion");
	AST_RESULT: assert property ($changed(result_o) |-> $fell(conversion_busy_flag_o))
		else $error("result changed away from end of conversion");
	AST_IRQ: assert property ($past(resetn_i) |-> irq_o == (irq_flag_o && $past(global_irq_enable_i)
		&& $past(converter_irq_enable_i))) else $error("interrupt output wrong");
endmodule // adsc_top_sva

bind adsc_top adsc_top_sva #(.RES_W(RES_W), .CONV_PERIODS(CONV_PERIODS), .NUM_PINS(NUM_PINS)) u_sva (.*);

// *** verif/testbench.sv ***
// self-checking bench for adsc_top: steering, power, start/busy timing, result and interrupt request
// assumes an ideal comparator: the analog input is a code compared against the trial code
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", n, e, a); end end

module testbench;
	logic ref_clk_i, resetn_i, start_i, irq_flag_clr_i, comparator_i;
	logic converter_power_down_i, reference_source_sel_i, extended_channel_sel_i;
	logic global_irq_enable_i, converter_irq_enable_i;
	logic [2:0] conv_clock_divider_sel_i, channel_select_field_i;
	logic [7:0] analog_pin_enables_i, port_direction_in_i, pullup_en_i;
	logic converter_powered_o, sample_o, vref_pin_ref_o, vref_pin_other_en_o;
	logic conversion_busy_flag_o, irq_flag_o, irq_o;
	logic [11:0] dac_code_o, result_o, vin;
	logic [3:0] channel_o;
	logic [7:0] pin_analog_o, pin_digital_en_o, pin_dir_in_o, pin_pullup_o;
	logic [11:0] vals[4] = '{12'h000, 12'hfff, 12'ha5c, 12'h801};
	int errors = 0;
	int checked = 0;
	int n;

	adsc_top dut (.*);
	assign comparator_i = vin >= dac_code_o;

	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk_i);
		#2;
	endtask

	task automatic wrap_up;
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// start held high for h cycles, then released; n counts edges until busy reads low
	task automatic convert(input logic [11:0] v, input logic [2:0] sel, input int h);
		vin = v;
		conv_clock_divider_sel_i = sel;
		start_i = 1'b1;
		tick(h);
		`CHK("busy", 1'b1, conversion_busy_flag_o)
		`CHK("early", 1'b0, irq_flag_o)
		`CHK("nosample", 1'b0, sample_o)
		start_i = 1'b0;
		tick(1);
		`CHK("sample", 1'b1, sample_o)
		n = 0;
		while (conversion_busy_flag_o !== 1'b0 && n < 2000) begin
			tick(1);
			n++;
		end
		`CHK("sampleoff", 1'b0, sample_o)
	endtask

	task automatic clear_flag;
		irq_flag_clr_i = 1'b1;
		tick(1);
		irq_flag_clr_i = 1'b0;
		`CHK("irqclr", 1'b0, irq_flag_o)
	endtask

	initial begin
		#500000;
		errors++;
		wrap_up();
	end

	initial begin
		{resetn_i, start_i, irq_flag_clr_i, converter_power_down_i, reference_source_sel_i} = '0;
		{global_irq_enable_i, converter_irq_enable_i, extended_channel_sel_i, channel_select_field_i} = '0;
		{analog_pin_enables_i, port_direction_in_i, pullup_en_i, vin} = '0;
		conv_clock_divider_sel_i = 3'h2;
		tick(12);
		resetn_i = 1'b1;
		for (int i = 0; i < 4; i++) begin
			analog_pin_enables_i = 8'h11 << i;
			port_direction_in_i = 8'h33 << i;
			pullup_en_i = 8'hf0 >> i;
			reference_source_sel_i = i[0];
			converter_power_down_i = i[1];
			{extended_channel_sel_i, channel_select_field_i} = 4'(6 + i);
			tick(1);
			`CHK("channel", 4'(6 + i), channel_o)
			`CHK("analog", analog_pin_enables_i, pin_analog_o)
			`CHK("digital", ~analog_pin_enables_i, pin_digital_en_o)
			`CHK("dir", port_direction_in_i | analog_pin_enables_i, pin_dir_in_o)
			`CHK("pullup", pullup_en_i & ~analog_pin_enables_i, pin_pullup_o)
			`CHK("ref", i[0], vref_pin_ref_o)
			`CHK("refother", !i[0], vref_pin_other_en_o)
			`CHK("power", !i[1], converter_powered_o)
		end
		{converter_power_down_i, reference_source_sel_i} = '0;
		{global_irq_enable_i, converter_irq_enable_i} = 2'h3;
		tick(2);
		// codes 000 and 001 outrun the comparator synchroniser, so their result is not judged
		for (int s = 0; s < 7; s++) begin
			convert(vals[s % 4], s[2:0], 1);
			`CHK("cycles", (16 << s) + 1, n)
			if (s >= 2)
				`CHK("result", vals[s % 4], result_o)
			`CHK("irqflag", 1'b1, irq_flag_o)
			`CHK("irq", 1'b1, irq_o)
			clear_flag();
		end
		converter_irq_enable_i = 1'b0;
		convert(12'h0f0, 3'h2, 100);
		`CHK("held", 12'h0f0, result_o)
		`CHK("masked", 1'b0, irq_o)
		clear_flag();
		vin = 12'h555;
		start_i = 1'b1;
		tick(1);
		start_i = 1'b0;
		tick(10);
		converter_power_down_i = 1'b1;
		tick(200);
		`CHK("offresult", 12'h0f0, result_o)
		`CHK("offflag", 1'b0, irq_flag_o)
		converter_power_down_i = 1'b0;
		{global_irq_enable_i, converter_irq_enable_i} = 2'h1;
		tick(2);
		convert(12'h2aa, 3'h2, 1);
		`CHK("after", 12'h2aa, result_o)
		`CHK("globalmask", 1'b0, irq_o)
		`CHK("flagset", 1'b1, irq_flag_o)
		converter_power_down_i = 1'b1;
		tick(1);
		`CHK("offend", 1'b0, converter_powered_o)
		wrap_up();
	end
endmodule // testbench
